// file: rtl/ptp_port_regs_pkg.sv
`default_nettype none
package ptp_port_regs_pkg;

  // register bus geometry
  localparam int ADDR_W = 9;
  localparam int DATA_W = 32;

  // byte offsets of the registers handled here
  localparam logic [8:0] OFF_BANK_SELECT = 9'h154;
  localparam logic [8:0] OFF_RX_PARSE = 9'h158;
  localparam logic [8:0] OFF_ASYM_PEER = 9'h15c;
  localparam logic [8:0] OFF_CAP_INFO = 9'h160;

  // bank select field
  localparam int BANK_SEL_LSB = 0;
  localparam int BANK_SEL_W = 3;
  localparam logic [2:0] BANK_SEL_RESET = 3'h0;
  localparam logic [2:0] BANK_PORT_GENERAL = 3'h0;
  localparam logic [2:0] BANK_PORT_RX = 3'h1;
  localparam logic [2:0] BANK_PORT_TX = 3'h2;
  localparam logic [2:0] BANK_GPIO = 3'h3;

  // asymmetry / peer delay fields
  localparam int ASYM_LSB = 16;
  localparam int PEER_LSB = 0;
  localparam int DELAY_W = 16;
  localparam logic [15:0] ASYM_RESET = 16'h0000;
  localparam logic [15:0] PEER_RESET = 16'h0000;

  // capture info fields
  localparam int TX_CNT_LSB = 4;
  localparam int RX_CNT_LSB = 0;
  localparam int CNT_FIELD_W = 3;
  localparam logic [2:0] CNT_RESET = 3'h0;

  // parse enables: index 3 is bit 14 down to index 0 at bit 11
  localparam int PARSE_LSB = 11;
  localparam int PARSE_W = 4;
  localparam int PE_IP_SECOND = 0;
  localparam int PE_IP_FIRST = 1;
  localparam int PE_L2_SECOND = 2;
  localparam int PE_L2_FIRST = 3;
  localparam logic [3:0] PARSE_RESET = 4'he;

  // well-known destinations
  localparam logic [47:0] MAC_L2_FIRST = 48'h0180_c200_000e;
  localparam logic [47:0] MAC_L2_SECOND = 48'h011b_1900_0000;
  localparam logic [47:0] MAC_V4_FIRST = 48'h0100_5e00_0181;
  localparam logic [47:0] MAC_V4_SECOND = 48'h0100_5e00_0182;
  localparam logic [47:0] MAC_V6_FIRST = 48'h3333_0000_0181;
  localparam logic [47:0] MAC_V6_SECOND = 48'h3333_0000_0182;
  localparam logic [31:0] IP4_FIRST = 32'he000_0181;
  localparam logic [31:0] IP4_SECOND = 32'he000_0182;
  // ipv6 ff0x::18y, the scope nibble x is a wildcard
  localparam logic [11:0] IP6_PREFIX = 12'hff0;
  localparam logic [15:0] IP6_FIRST_TAIL = 16'h0181;
  localparam logic [15:0] IP6_SECOND_TAIL = 16'h0182;

endpackage

`default_nettype wire

// file: rtl/ptp_dest_matcher.sv
`timescale 1ns/1ps
`default_nettype none

module ptp_dest_matcher (
  // frame description
  input wire logic is_l2_in,
  input wire logic is_ipv4_in,
  input wire logic is_ipv6_in,
  input wire logic [47:0] dest_mac_in,
  input wire logic [31:0] ipv4_dest_in,
  input wire logic [127:0] ipv6_dest_in,
  // enables
  input wire logic [3:0] parse_enable_in,
  // result
  output logic match_out
);

  function automatic logic ipv6_hit(input logic [127:0] ip, input logic [15:0] tail);
    ipv6_hit = (ip[127:116] == ptp_port_regs_pkg::IP6_PREFIX) && (ip[111:16] == 96'h0) && (ip[15:0] == tail);
  endfunction

  wire logic l2_first_accept;
  wire logic l2_second_accept;
  wire logic v4_first;
  wire logic v4_second;
  wire logic v6_first;
  wire logic v6_second;

  assign l2_first_accept = parse_enable_in[ptp_port_regs_pkg::PE_L2_FIRST] && is_l2_in &&
                           (dest_mac_in == ptp_port_regs_pkg::MAC_L2_FIRST);
  assign l2_second_accept = parse_enable_in[ptp_port_regs_pkg::PE_L2_SECOND] && is_l2_in &&
                            (dest_mac_in == ptp_port_regs_pkg::MAC_L2_SECOND);
  assign v4_first = is_ipv4_in && (dest_mac_in == ptp_port_regs_pkg::MAC_V4_FIRST) &&
                    (ipv4_dest_in == ptp_port_regs_pkg::IP4_FIRST);
  assign v6_first = is_ipv6_in && (dest_mac_in == ptp_port_regs_pkg::MAC_V6_FIRST) &&
                    ipv6_hit(ipv6_dest_in, ptp_port_regs_pkg::IP6_FIRST_TAIL);
  assign v4_second = is_ipv4_in && (dest_mac_in == ptp_port_regs_pkg::MAC_V4_SECOND) &&
                     (ipv4_dest_in == ptp_port_regs_pkg::IP4_SECOND);
  assign v6_second = is_ipv6_in && (dest_mac_in == ptp_port_regs_pkg::MAC_V6_SECOND) &&
                     ipv6_hit(ipv6_dest_in, ptp_port_regs_pkg::IP6_SECOND_TAIL);

  assign match_out = l2_first_accept || l2_second_accept ||
                     (parse_enable_in[ptp_port_regs_pkg::PE_IP_FIRST] &&
                      (v4_first || v6_first)) ||
                     (parse_enable_in[ptp_port_regs_pkg::PE_IP_SECOND] &&
                      (v4_second || v6_second));

endmodule

`default_nettype wire

// file: rtl/ptp_port_parse_capture_regs.sv
// Behaviour
// - asymmetry field in bits 31:16 is signed read/write nanoseconds, reset zero.
// - positive asymmetry means forward path longer than reverse; negative the opposite.
// - peer delay field in bits 15:0 is read/write, reset zero, used in peer mode.
// - capture info register is read-only and reports buffered timestamp counts.
// - transmit count rises per transmitted packet, falls per transmit flag clear.
// - receive count rises per received packet, falls per receive flag clear.
// - parse configuration sits at the latency offset but only in bank one.
// - bit 14 enables layer 2 destination 01:80:C2:00:00:0E, reset one.
// - bit 13 enables layer 2 destination 01:1B:19:00:00:00, reset one.
// - bit 12 enables IPv4 destination 224.0.1.129 with its multicast MAC.
// - bit 12 also enables IPv6 destination FF0X::181 with its multicast MAC.
// - bit 11 enables IPv4 destination 224.0.1.130 with its multicast MAC, reset zero.
// - bit 11 also enables IPv6 destination FF0X::182 with its multicast MAC.
// - three-bit bank select picks port general, receive, transmit or GPIO bank.
`timescale 1ns/1ps
`default_nettype none

module ptp_port_parse_capture_regs #(
  parameter int COUNT_W = 3
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic nrst_in,
  // register port
  input wire logic [8:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  // timestamp engine events, same clock
  input wire logic tx_stamp_in,
  input wire logic rx_stamp_in,
  input wire logic tx_flag_clear_in,
  input wire logic rx_flag_clear_in,
  // port mode
  input wire logic ptp_enable_in,
  input wire logic peer_mode_in,
  // received frame description, same clock
  input wire logic frame_valid_in,
  input wire logic frame_is_l2_in,
  input wire logic frame_is_ipv4_in,
  input wire logic frame_is_ipv6_in,
  input wire logic [47:0] dest_mac_in,
  input wire logic [31:0] ipv4_dest_in,
  input wire logic [127:0] ipv6_dest_in,
  // configuration towards the engine
  output logic [15:0] asymmetry_out,
  output logic [15:0] peer_delay_out,
  output logic [2:0] bank_select_out,
  output logic [3:0] parse_enable_out,
  // status
  output logic [COUNT_W-1:0] tx_stamp_count_out,
  output logic [COUNT_W-1:0] rx_stamp_count_out,
  output logic ptp_match_out,
  output logic ptp_match_valid_out,
  output logic cfg_change_while_enabled_out
);

  // the count fields are three bits wide in the map; wider counts would overlap
  if (COUNT_W < 1 || COUNT_W > ptp_port_regs_pkg::CNT_FIELD_W) begin : g_bad_count
    $error("COUNT_W must be between 1 and 3");
  end

  localparam logic [COUNT_W-1:0] CNT_MAX = {COUNT_W{1'b1}};

  // saturating up/down step; simultaneous up and down cancel out
  function automatic logic [COUNT_W-1:0] step_count(input logic [COUNT_W-1:0] cnt,
                                                    input logic up,
                                                    input logic down);
    logic [COUNT_W-1:0] res;
    res = cnt;
    if (up && !down && cnt != CNT_MAX) begin
      res = cnt + 1'b1;
    end else if (down && !up && cnt != '0) begin
      res = cnt - 1'b1;
    end
    step_count = res;
  endfunction

  // state
  logic [2:0] bank_select;
  logic signed [15:0] asymmetry;
  logic [15:0] peer_delay;
  logic [3:0] parse_enable;
  logic [COUNT_W-1:0] tx_stamp_count;
  logic [COUNT_W-1:0] rx_stamp_count;
  logic [31:0] read_data;
  logic applied_match;
  logic match_valid;
  logic cfg_change_while_enabled;

  // decode
  wire logic bank_general;
  wire logic bank_rx;
  wire logic hit_bank_select;
  wire logic hit_rx_parse;
  wire logic hit_asym_peer;
  wire logic hit_cap_info;
  wire logic wr_bank_select;
  wire logic wr_rx_parse;
  wire logic wr_asym_peer;
  wire logic guarded_write;
  wire logic [31:0] bank_select_word;
  wire logic [31:0] rx_parse_word;
  wire logic [31:0] asym_peer_word;
  wire logic [31:0] cap_info_word;
  wire logic [31:0] next_read_data;
  wire logic [COUNT_W-1:0] next_tx_stamp_count;
  wire logic [COUNT_W-1:0] next_rx_stamp_count;
  wire logic frame_match;

  assign bank_general = (bank_select == ptp_port_regs_pkg::BANK_PORT_GENERAL);
  assign bank_rx = (bank_select == ptp_port_regs_pkg::BANK_PORT_RX);

  assign hit_bank_select = (addr_in == ptp_port_regs_pkg::OFF_BANK_SELECT);
  // the latency register of bank zero lives elsewhere; only bank one reaches parse config
  assign hit_rx_parse = (addr_in == ptp_port_regs_pkg::OFF_RX_PARSE) && bank_rx;
  assign hit_asym_peer = (addr_in == ptp_port_regs_pkg::OFF_ASYM_PEER) && bank_general;
  assign hit_cap_info = (addr_in == ptp_port_regs_pkg::OFF_CAP_INFO) && bank_general;

  assign wr_bank_select = wr_in && hit_bank_select;
  assign wr_rx_parse = wr_in && hit_rx_parse;
  assign wr_asym_peer = wr_in && hit_asym_peer;
  // writes to the capture info word are dropped, so counts cannot be forced
  assign guarded_write = ptp_enable_in && (wr_rx_parse || wr_asym_peer);

  // read words, reserved bits held at zero
  assign bank_select_word = {29'h0, bank_select};
  assign rx_parse_word = {17'h0, parse_enable, 11'h0};
  assign asym_peer_word = {asymmetry, peer_delay};
  assign cap_info_word = {25'h0,
                          (ptp_port_regs_pkg::CNT_FIELD_W)'(tx_stamp_count),
                          1'b0,
                          (ptp_port_regs_pkg::CNT_FIELD_W)'(rx_stamp_count)};

  assign next_read_data = !rd_in ? 32'h0 :
                          hit_bank_select ? bank_select_word :
                          hit_rx_parse ? rx_parse_word :
                          hit_asym_peer ? asym_peer_word :
                          hit_cap_info ? cap_info_word : 32'h0;

  assign next_tx_stamp_count = step_count(tx_stamp_count, tx_stamp_in, tx_flag_clear_in);
  assign next_rx_stamp_count = step_count(rx_stamp_count, rx_stamp_in, rx_flag_clear_in);

  ptp_dest_matcher u_matcher (
    .is_l2_in(frame_is_l2_in),
    .is_ipv4_in(frame_is_ipv4_in),
    .is_ipv6_in(frame_is_ipv6_in),
    .dest_mac_in(dest_mac_in),
    .ipv4_dest_in(ipv4_dest_in),
    .ipv6_dest_in(ipv6_dest_in),
    .parse_enable_in(parse_enable),
    .match_out(frame_match)
  );

  // bank select
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bank_select <= ptp_port_regs_pkg::BANK_SEL_RESET;
    end else if (wr_bank_select) begin
      bank_select <= wdata_in[ptp_port_regs_pkg::BANK_SEL_LSB +: ptp_port_regs_pkg::BANK_SEL_W];
    end
  end

  // asymmetry and peer delay
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      asymmetry <= ptp_port_regs_pkg::ASYM_RESET;
      peer_delay <= ptp_port_regs_pkg::PEER_RESET;
    end else if (wr_asym_peer) begin
      asymmetry <= wdata_in[ptp_port_regs_pkg::ASYM_LSB +: ptp_port_regs_pkg::DELAY_W];
      peer_delay <= wdata_in[ptp_port_regs_pkg::PEER_LSB +: ptp_port_regs_pkg::DELAY_W];
    end
  end

  // parse enables
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      parse_enable <= ptp_port_regs_pkg::PARSE_RESET;
    end else if (wr_rx_parse) begin
      parse_enable <= wdata_in[ptp_port_regs_pkg::PARSE_LSB +: ptp_port_regs_pkg::PARSE_W];
    end
  end

  // timestamp counts
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_stamp_count <= COUNT_W'(ptp_port_regs_pkg::CNT_RESET);
      rx_stamp_count <= COUNT_W'(ptp_port_regs_pkg::CNT_RESET);
    end else begin
      tx_stamp_count <= next_tx_stamp_count;
      rx_stamp_count <= next_rx_stamp_count;
    end
  end

  // read data stands for one cycle only
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      read_data <= 32'h0;
    end else begin
      read_data <= next_read_data;
    end
  end

  // frame classification, one cycle after frame_valid_in
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      applied_match <= 1'b0;
      match_valid <= 1'b0;
    end else begin
      match_valid <= frame_valid_in;
      applied_match <= frame_valid_in && frame_match;
    end
  end

  // one-cycle warning when software writes settings the running engine depends on
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cfg_change_while_enabled <= 1'b0;
    end else begin
      cfg_change_while_enabled <= guarded_write;
    end
  end

  // outputs
  assign rdata_out = read_data;
  // signed: positive means the forward path is slower than the reverse path
  assign asymmetry_out = asymmetry;
  assign peer_delay_out = peer_delay;
  assign bank_select_out = bank_select;
  assign parse_enable_out = parse_enable;
  assign tx_stamp_count_out = tx_stamp_count;
  assign rx_stamp_count_out = rx_stamp_count;
  assign ptp_match_out = applied_match;
  assign ptp_match_valid_out = match_valid;
  assign cfg_change_while_enabled_out = cfg_change_while_enabled;

  // peer_mode_in only qualifies how the engine uses peer_delay_out; it is not stored here
  wire logic unused_peer_mode;
  assign unused_peer_mode = peer_mode_in;

endmodule

`default_nettype wire

// file: verification/ptp_regs_props.sv
`timescale 1ns/1ps
`default_nettype none
module ptp_regs_props #(parameter int COUNT_W = 3) (
  // clock, reset and register port
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [8:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [31:0] rdata_out,
  // events and frames
  input wire logic tx_stamp_in,
  input wire logic rx_stamp_in,
  input wire logic tx_flag_clear_in,
  input wire logic rx_flag_clear_in,
  input wire logic ptp_enable_in,
  input wire logic frame_valid_in,
  input wire logic frame_is_l2_in,
  input wire logic [47:0] dest_mac_in,
  // outputs
  input wire logic [15:0] asymmetry_out,
  input wire logic [15:0] peer_delay_out,
  input wire logic [2:0] bank_select_out,
  input wire logic [3:0] parse_enable_out,
  input wire logic [COUNT_W-1:0] tx_stamp_count_out,
  input wire logic [COUNT_W-1:0] rx_stamp_count_out,
  input wire logic ptp_match_out,
  input wire logic ptp_match_valid_out,
  input wire logic cfg_change_while_enabled_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  wire logic bank0 = bank_select_out == 3'h0;
  wire logic wr_asym = wr_in && addr_in == 9'h15c && bank0;
  wire logic wr_parse = wr_in && addr_in == 9'h158 && bank_select_out == 3'h1;
  wire logic guarded_cfg_write = ptp_enable_in && (wr_asym || wr_parse);
  AST_RDATA_IDLE: assert property (!$past(rd_in) |-> rdata_out == 32'h0)
    else $error("read data not zero outside read slot");
  AST_CAP_READ: assert property (rd_in && addr_in == 9'h160 && bank0 |=> rdata_out[31:7] == 25'h0
    && !rdata_out[3] && rdata_out[6:4] == $past(tx_stamp_count_out) && rdata_out[2:0] == $past(rx_stamp_count_out))
    else $error("capture info read wrong");
  AST_ASYM_WR: assert property (wr_asym |=> {asymmetry_out, peer_delay_out} == $past(wdata_in))
    else $error("asymmetry write not applied");
  AST_PARSE_WR: assert property (wr_parse |=> parse_enable_out == $past(wdata_in[14:11]))
    else $error("parse write not applied");
  AST_PARSE_HOLD: assert property (!wr_parse |=> $stable(parse_enable_out))
    else $error("parse enables changed without write");
  AST_TX_INC: assert property (tx_stamp_in && !tx_flag_clear_in && tx_stamp_count_out != '1
    |=> tx_stamp_count_out == $past(tx_stamp_count_out) + 1'b1) else $error("tx count did not rise");
  AST_TX_DEC: assert property (tx_flag_clear_in && !tx_stamp_in && tx_stamp_count_out != '0
    |=> tx_stamp_count_out == $past(tx_stamp_count_out) - 1'b1) else $error("tx count did not fall");
  AST_RX_INC: assert property (rx_stamp_in && !rx_flag_clear_in && rx_stamp_count_out != '1
    |=> rx_stamp_count_out == $past(rx_stamp_count_out) + 1'b1) else $error("rx count did not rise");
  AST_RX_DEC: assert property (rx_flag_clear_in && !rx_stamp_in && rx_stamp_count_out != '0
    |=> rx_stamp_count_out == $past(rx_stamp_count_out) - 1'b1) else $error("rx count did not fall");
  AST_L2_MATCH: assert property (frame_valid_in && frame_is_l2_in && dest_mac_in == 48'h0180_c200_000e
    |=> ptp_match_valid_out && ptp_match_out == $past(parse_enable_out[3])) else $error("l2 match wrong");
  AST_CFG_WARN: assert property (guarded_cfg_write |=> cfg_change_while_enabled_out)
    else $error("settings write while enabled not flagged");
  AST_CFG_QUIET: assert property (!guarded_cfg_write |=> !cfg_change_while_enabled_out)
    else $error("settings warning without guarded write");
  cover property (wr_asym);
  cover property (ptp_match_out);
  cover property (tx_stamp_count_out == '1);
  cover property (cfg_change_while_enabled_out);
endmodule
bind ptp_port_parse_capture_regs ptp_regs_props #(.COUNT_W(COUNT_W)) props_i (.clk_in, .nrst_in, .addr_in,
  .wdata_in, .wr_in, .rd_in, .rdata_out, .tx_stamp_in, .rx_stamp_in, .tx_flag_clear_in, .rx_flag_clear_in,
  .frame_valid_in, .frame_is_l2_in, .dest_mac_in, .asymmetry_out, .peer_delay_out, .bank_select_out,
  .parse_enable_out, .tx_stamp_count_out, .rx_stamp_count_out, .ptp_match_out, .ptp_match_valid_out,
  .ptp_enable_in, .cfg_change_while_enabled_out);
`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      mismatches++; \
      $display("unexpected %s exp %h got %h", nm, e, g); \
    end \
  end
module tb;
  logic clk_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0, ptp_enable_in = 1'b0, peer_mode_in = 1'b0;
  logic tx_stamp_in = 1'b0, rx_stamp_in = 1'b0, tx_flag_clear_in = 1'b0, rx_flag_clear_in = 1'b0;
  logic frame_valid_in = 1'b0, frame_is_l2_in = 1'b0, frame_is_ipv4_in = 1'b0, frame_is_ipv6_in = 1'b0;
  logic [8:0] addr_in = 9'h0;
  logic [31:0] wdata_in = 32'h0, ipv4_dest_in = 32'h0, rdata_out;
  logic [47:0] dest_mac_in = 48'h0;
  logic [127:0] ipv6_dest_in = 128'h0;
  logic [15:0] asymmetry_out, peer_delay_out;
  logic [2:0] bank_select_out, tx_stamp_count_out, rx_stamp_count_out;
  logic [3:0] parse_enable_out;
  logic ptp_match_out, ptp_match_valid_out, cfg_change_while_enabled_out;
  int mismatches = 0, samples_checked = 0, cycles = 0;
  logic [47:0] macs [6] = '{ptp_port_regs_pkg::MAC_L2_FIRST, ptp_port_regs_pkg::MAC_L2_SECOND,
    ptp_port_regs_pkg::MAC_V4_FIRST, ptp_port_regs_pkg::MAC_V6_FIRST, ptp_port_regs_pkg::MAC_V4_SECOND,
    ptp_port_regs_pkg::MAC_V6_SECOND};
  int bits [6] = '{3, 2, 1, 1, 0, 0};
  int kinds [6] = '{0, 0, 1, 2, 1, 2};

  ptp_port_parse_capture_regs #(.COUNT_W(3)) uut (.clk_in, .nrst_in, .addr_in, .wdata_in, .wr_in, .rd_in,
    .rdata_out, .tx_stamp_in, .rx_stamp_in, .tx_flag_clear_in, .rx_flag_clear_in, .ptp_enable_in,
    .peer_mode_in, .frame_valid_in, .frame_is_l2_in, .frame_is_ipv4_in, .frame_is_ipv6_in, .dest_mac_in,
    .ipv4_dest_in, .ipv6_dest_in, .asymmetry_out, .peer_delay_out, .bank_select_out, .parse_enable_out,
    .tx_stamp_count_out, .rx_stamp_count_out, .ptp_match_out, .ptp_match_valid_out,
    .cfg_change_while_enabled_out);

  initial begin
    forever #5 clk_in = ~clk_in;
  end

  task complete_run;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // a hang on any task below ends here rather than running forever
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      complete_run();
    end
  end

  task wr(input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // read data only stand in the slot after the strobe, so look there
  task rd(input logic [8:0] a, input logic [31:0] e);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 `CHK("rdata", e, rdata_out)
  endtask

  // v holds tx inc, rx inc, tx clear, rx clear for n cycles
  task ev(input logic [3:0] v, input int n);
    repeat (n) begin
      @(posedge clk_in);
      {tx_stamp_in, rx_stamp_in, tx_flag_clear_in, rx_flag_clear_in} <= v;
    end
  endtask

  task frame(input int i, input logic [3:0] en, input logic e);
    wr(9'h158, {17'h0, en, 11'h0});
    @(posedge clk_in);
    frame_valid_in <= 1'b1;
    frame_is_l2_in <= kinds[i] == 0;
    frame_is_ipv4_in <= kinds[i] == 1;
    frame_is_ipv6_in <= kinds[i] == 2;
    dest_mac_in <= macs[i];
    ipv4_dest_in <= bits[i] == 0 ? ptp_port_regs_pkg::IP4_SECOND : ptp_port_regs_pkg::IP4_FIRST;
    // scope nibble 5 shows it is not compared
    ipv6_dest_in <= {ptp_port_regs_pkg::IP6_PREFIX, 4'h5, 96'h0,
      bits[i] == 0 ? ptp_port_regs_pkg::IP6_SECOND_TAIL : ptp_port_regs_pkg::IP6_FIRST_TAIL};
    @(posedge clk_in);
    frame_valid_in <= 1'b0;
    #1 `CHK("match", {1'b1, e}, {ptp_match_valid_out, ptp_match_out})
  endtask

  initial begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    rd(9'h15c, 32'h0);
    rd(9'h160, 32'h0);
    rd(9'h158, 32'h0);
    rd(9'h154, 32'h0);
    wr(9'h154, 32'h1);
    rd(9'h154, 32'h1);
    `CHK("bank", 3'h1, bank_select_out)
    rd(9'h158, 32'h0000_7000);
    `CHK("parse", 4'he, parse_enable_out)
    rd(9'h15c, 32'h0);
    wr(9'h158, 32'hffff_ffff);
    rd(9'h158, 32'h0000_7800);
    for (int i = 0; i < 6; i++) begin
      frame(i, 4'hf, 1'b1);
      frame(i, 4'hf ^ (4'h1 << bits[i]), 1'b0);
    end
    wr(9'h154, 32'h2);
    rd(9'h158, 32'h0);
    wr(9'h154, 32'h0);
    wr(9'h15c, 32'hfff6_0064);
    #1 `CHK("cfg_warn", 1'b0, cfg_change_while_enabled_out)
    rd(9'h15c, 32'hfff6_0064);
    `CHK("asym", 16'hfff6, asymmetry_out)
    `CHK("peer", 16'h0064, peer_delay_out)
    // rewriting the same value while enabled still raises the warning
    @(posedge clk_in);
    ptp_enable_in <= 1'b1;
    wr(9'h15c, 32'hfff6_0064);
    #1 `CHK("cfg_warn", 1'b1, cfg_change_while_enabled_out)
    @(posedge clk_in);
    ptp_enable_in <= 1'b0;
    #1 `CHK("cfg_warn", 1'b0, cfg_change_while_enabled_out)
    ev(4'hc, 3);
    ev(4'hb, 1);
    ev(4'h0, 1);
    rd(9'h160, 32'h0000_0032);
    wr(9'h160, 32'hffff_ffff);
    rd(9'h160, 32'h0000_0032);
    ev(4'h8, 8);
    ev(4'h1, 4);
    ev(4'h0, 1);
    rd(9'h160, 32'h0000_0070);
    `CHK("tx_count", 3'h7, tx_stamp_count_out)
    ev(4'h2, 2);
    ev(4'h0, 1);
    rd(9'h160, 32'h0000_0050);
    `CHK("rx_count", 3'h0, rx_stamp_count_out)
    complete_run();
  end
endmodule
`default_nettype wire
